//--- design/usp_pkg.sv
// package for the uart select / modem / interrupt pin block
// assumes a single 20 MHz clock domain and synchronous active-low reset
package usp_pkg;
    // modem status register bit positions
    localparam int MSR_CTS_CHG = 0;
    localparam int MSR_DSR_CHG = 1;
    localparam int MSR_RI_EDGE = 2;
    localparam int MSR_DCD_CHG = 3;
    localparam int MSR_CTS = 4;
    localparam int MSR_DSR = 5;
    localparam int MSR_RI = 6;
    localparam int MSR_DCD = 7;
    // modem control register bit positions
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_USER_OUTPUT_ONE = 2;
    localparam int MCR_USER_OUTPUT_TWO = 3;
    localparam int MCR_LOOP = 4;
    // reset values
    localparam logic [7:0] MCR_RESET = 8'h00;
    localparam logic [7:0] MSR_CHG_RESET = 8'h00;
    // receive clock divisor: 16 ticks per bit
    localparam int RCLK_OVERSAMPLE = 16;

    // chip select inputs travel together
    typedef struct packed {
        logic high_a;
        logic high_b;
        logic low_n;
    } usp_sel_t;

    // interrupt source requests from the rest of the uart
    typedef struct packed {
        logic rx_error;
        logic rx_data;
        logic rx_timeout;
        logic thr_empty;
    } usp_irq_src_t;

    // modem input levels (pins are active low)
    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic ri_n;
        logic dcd_n;
    } usp_modem_in_t;
endpackage

//--- design/usp_pins.sv
// pin-level select, data bus, modem status/control and interrupt logic
// assumes all pins asynchronous to clock; datapath beyond the pins external
//
// Contract
// - selected only when both high selects high and low select low.
// - any select inactive means unselected; read and write strobes ignored.
// - cts level at status bit 4, change flag at bit 0.
// - cts change interrupts only with modem irq enabled, auto-cts off.
// - auto-cts mode gates transmitter with cts input.
// - carrier detect level at bit 7, change flag bit 3, interrupts.
// - data set ready level bit 5, change flag bit 1, interrupts.
// - transceiver disable high except during selected reads.
// - terminal ready low when control bit set; high on reset, loop.
// - interrupt high when any enabled source is pending; timeout counts only in fifo mode.
// - interrupt drops once serviced or on master reset.
// - master reset clears control register and change flags; forces outputs but rx_tick_out to reset levels.
// - user outputs low per control bits 2, 3; high reset, loop.
// - receiver timed by its own 16x receive clock input.
// - eight-bit bus driven only during selected reads, else released.
// - address strobe low passes selects; rising edge latches them.
`timescale 1ns/10ps
module usp_pins
    import usp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic master_reset_in,
    input wire usp_pkg::usp_sel_t chip_sel_in,
    input wire logic address_latch_strobe_n,
    input wire logic [2:0] reg_sel_in,
    input wire logic read_n_in,
    input wire logic read_in,
    input wire logic write_n_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic [7:0] data_oe_n,
    output logic transceiver_disable_out,
    input wire usp_pkg::usp_modem_in_t modem_in,
    input wire logic rclk_in,
    input wire usp_pkg::usp_irq_src_t irq_src_in,
    input wire logic [3:0] irq_enable_in,
    input wire logic fifo_mode_in,
    input wire logic auto_cts_in,
    input wire logic irq_service_in,
    output logic interrupt_out,
    output logic terminal_ready_n_out,
    output logic request_send_n_out,
    output logic user_output_one_n,
    output logic user_output_two_n,
    output logic tx_permit_out,
    output logic rx_tick_out,
    output logic [7:0] modem_control_reg_q,
    output logic [2:0] reg_sel_q,
    output logic reg_read_stb,
    output logic reg_write_stb
);
    import usp_pkg::*;

    localparam logic [2:0] MSR_ADDR = 3'h6;
    localparam logic [2:0] MCR_ADDR = 3'h4;

    // two-flop synchronisers for every pin input except the data bus
    // reset to the idle pin levels, so no false change or edge after reset
    // order: mr, selects, strobe, reg select, rd_n, rd, wr_n, rclk, cts_n
    localparam logic [12:0] PIN_IDLE = 13'h0315;
    logic [12:0] pin_raw, pin_s1, pin_s2;
    assign pin_raw = {master_reset_in, chip_sel_in, address_latch_strobe_n,
                      reg_sel_in, read_n_in, read_in, write_n_in, rclk_in,
                      modem_in.cts_n};
    logic [2:0] mod_s1, mod_s2;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
            mod_s1 <= 3'h7;
            mod_s2 <= 3'h7;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            mod_s1 <= {modem_in.dsr_n, modem_in.ri_n, modem_in.dcd_n};
            mod_s2 <= mod_s1;
        end
    end

    logic mr_s, as_n_s, rd_n_s, rd_s, wr_n_s, rclk_s, cts_n_s;
    logic dsr_n_s, ri_n_s, dcd_n_s;
    logic [2:0] sel_s, rs_s;
    assign {mr_s, sel_s, as_n_s, rs_s, rd_n_s, rd_s, wr_n_s, rclk_s,
            cts_n_s} = pin_s2;
    assign {dsr_n_s, ri_n_s, dcd_n_s} = mod_s2;

    // address strobe latch: transparent low, hold from rising edge
    logic [2:0] sel_hold_r, rs_hold_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sel_hold_r <= 3'h1;
            rs_hold_r <= 3'h0;
        end else if (!as_n_s) begin
            sel_hold_r <= sel_s;
            rs_hold_r <= rs_s;
        end
    end
    logic [2:0] sel_eff, rs_eff;
    assign sel_eff = as_n_s ? sel_hold_r : sel_s;
    assign rs_eff = as_n_s ? rs_hold_r : rs_s;

    // decode; unselected blocks both strobes
    logic selected, rd_act, wr_act;
    assign selected = sel_eff[2] & sel_eff[1] & ~sel_eff[0];
    assign rd_act = selected & (~rd_n_s | rd_s);
    assign wr_act = selected & ~wr_n_s;

    // edge detect so each access acts once
    logic rd_act_r, wr_act_r;
    always_ff @(posedge clock) begin
        if (!rst_n || mr_s) begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
        end else begin
            rd_act_r <= rd_act;
            wr_act_r <= wr_act;
        end
    end
    logic rd_rise, wr_rise;
    assign rd_rise = rd_act & ~rd_act_r;
    assign wr_rise = wr_act & ~wr_act_r;

    // modem control register, cleared by master reset
    always_ff @(posedge clock) begin
        if (!rst_n || mr_s) begin
            modem_control_reg_q <= MCR_RESET;
        end else if (wr_rise && rs_eff == MCR_ADDR) begin
            modem_control_reg_q <= data_in;
        end
    end
    logic loop_mode;
    assign loop_mode = modem_control_reg_q[MCR_LOOP];

    // previous levels for change detection
    logic [3:0] lvl_prev_r;
    logic [3:0] lvl_now;
    assign lvl_now = {~dcd_n_s, ~ri_n_s, ~dsr_n_s, ~cts_n_s};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lvl_prev_r <= 4'h0;
        end else begin
            lvl_prev_r <= lvl_now;
        end
    end

    // change flags; a new change wins over the read clear
    logic [3:0] chg_r, chg_set;
    assign chg_set[0] = lvl_now[0] ^ lvl_prev_r[0];
    assign chg_set[1] = lvl_now[1] ^ lvl_prev_r[1];
    assign chg_set[2] = lvl_prev_r[2] & ~lvl_now[2]; // ring trailing edge
    assign chg_set[3] = lvl_now[3] ^ lvl_prev_r[3];
    logic msr_read;
    assign msr_read = rd_rise && rs_eff == MSR_ADDR;
    always_ff @(posedge clock) begin
        if (!rst_n || mr_s) begin
            chg_r <= MSR_CHG_RESET[3:0];
        end else begin
            chg_r <= chg_set | (msr_read ? 4'h0 : chg_r);
        end
    end
    logic [7:0] msr_val;
    assign msr_val = {lvl_now, chg_r};

    // modem status interrupt: cts change ignored in auto-cts mode
    logic modem_pend;
    assign modem_pend = (chg_r[0] & ~auto_cts_in)
                      | chg_r[1] | chg_r[2] | chg_r[3];
    logic irq_any;
    assign irq_any = (irq_enable_in[2] & irq_src_in.rx_error)
                   | (irq_enable_in[0] & irq_src_in.rx_data)
                   | (irq_enable_in[0] & fifo_mode_in & irq_src_in.rx_timeout)
                   | (irq_enable_in[1] & irq_src_in.thr_empty)
                   | (irq_enable_in[3] & modem_pend);

    // interrupt output; service pulse drops it for one cycle, then it follows the pending sources
    always_ff @(posedge clock) begin
        if (!rst_n || mr_s) begin
            interrupt_out <= 1'b0;
        end else if (irq_service_in) begin
            interrupt_out <= 1'b0;
        end else begin
            interrupt_out <= irq_any;
        end
    end

    // modem control pins, inactive high in reset and loop
    always_ff @(posedge clock) begin
        if (!rst_n || mr_s || loop_mode) begin
            terminal_ready_n_out <= 1'b1;
            request_send_n_out <= 1'b1;
            user_output_one_n <= 1'b1;
            user_output_two_n <= 1'b1;
        end else begin
            terminal_ready_n_out <= ~modem_control_reg_q[MCR_DTR];
            request_send_n_out <= ~modem_control_reg_q[MCR_RTS];
            user_output_one_n <= ~modem_control_reg_q[MCR_USER_OUTPUT_ONE];
            user_output_two_n <= ~modem_control_reg_q[MCR_USER_OUTPUT_TWO];
        end
    end

    // transmitter gate; cts active low
    always_ff @(posedge clock) begin
        if (!rst_n || mr_s) begin
            tx_permit_out <= 1'b1;
        end else begin
            tx_permit_out <= ~auto_cts_in | ~cts_n_s;
        end
    end

    // receive 16x clock: one tick per rising edge of rclk
    logic rclk_prev_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rclk_prev_r <= 1'b0;
            rx_tick_out <= 1'b0;
        end else begin
            rclk_prev_r <= rclk_s;
            rx_tick_out <= rclk_s & ~rclk_prev_r;
        end
    end

    // data bus drive only during selected reads
    always_ff @(posedge clock) begin
        if (!rst_n || mr_s) begin
            data_out <= 8'h00;
            data_oe_n <= 8'hFF;
            transceiver_disable_out <= 1'b1;
        end else begin
            data_out <= (rs_eff == MSR_ADDR) ? msr_val :
                        (rs_eff == MCR_ADDR) ? modem_control_reg_q : 8'h00;
            data_oe_n <= rd_act ? 8'h00 : 8'hFF;
            transceiver_disable_out <= ~rd_act;
        end
    end

    // access strobes to the rest of the uart
    always_ff @(posedge clock) begin
        if (!rst_n || mr_s) begin
            reg_sel_q <= 3'h0;
            reg_read_stb <= 1'b0;
            reg_write_stb <= 1'b0;
        end else begin
            reg_sel_q <= rs_eff;
            reg_read_stb <= rd_rise;
            reg_write_stb <= wr_rise;
        end
    end
endmodule

//--- tb/usp_pins_checker.sv
// port assertions for the pin block
// assumes one clock domain; bound onto usp_pins
`timescale 1ns/10ps
module usp_chk
    import usp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic master_reset_in,
    input wire usp_pkg::usp_sel_t chip_sel_in,
    input wire logic address_latch_strobe_n,
    input wire logic irq_service_in,
    input wire logic [7:0] data_oe_n,
    input wire logic transceiver_disable_out,
    input wire logic interrupt_out,
    input wire logic terminal_ready_n_out,
    input wire logic user_output_one_n,
    input wire logic user_output_two_n,
    input wire logic rx_tick_out,
    input wire logic [7:0] modem_control_reg_q,
    input wire logic reg_read_stb,
    input wire logic reg_write_stb
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic ok;
    logic [7:0] m;
    // pins pass two sync flops, so idle must outlast that path
    assign ok = chip_sel_in.high_a & chip_sel_in.high_b & ~chip_sel_in.low_n;
    assign m = modem_control_reg_q;
    sequence unsel4;
        (!ok && !address_latch_strobe_n) [*4];
    endsequence
    sequence mr4;
        master_reset_in [*4];
    endsequence
    a_unsel_quiet: assert property (unsel4 |-> transceiver_disable_out
        && !reg_read_stb && !reg_write_stb) else $error("unselected access");
    a_bus_pair: assert property (
        (data_oe_n inside {8'h00, 8'hFF})
        && ((data_oe_n == 8'h00) == !transceiver_disable_out))
        else $error("bus drive and disable disagree");
    a_read_drives: assert property (
        reg_read_stb |-> !transceiver_disable_out && data_oe_n == 8'h00)
        else $error("read without bus drive");
    a_mr_levels: assert property (mr4 |=> !interrupt_out
        && terminal_ready_n_out && user_output_one_n && user_output_two_n
        && m == MCR_RESET && data_oe_n == 8'hFF) else $error("reset levels");
    a_dtr_mcr: assert property ($stable(m) |->
        terminal_ready_n_out == !(m[MCR_DTR] && !m[MCR_LOOP]))
        else $error("terminal ready wrong");
    a_user_mcr: assert property ($stable(m) |->
        {user_output_one_n, user_output_two_n}
        == ~({m[MCR_USER_OUTPUT_ONE], m[MCR_USER_OUTPUT_TWO]} & {2{!m[MCR_LOOP]}}))
        else $error("user outputs wrong");
    a_svc_drop: assert property (irq_service_in |=> !interrupt_out)
        else $error("interrupt kept after service");
    a_tick_pulse: assert property (rx_tick_out |=> !rx_tick_out)
        else $error("tick too long");
endmodule
bind usp_pins usp_chk i_chk (.clock(clock), .rst_n(rst_n),
    .master_reset_in(master_reset_in), .chip_sel_in(chip_sel_in),
    .address_latch_strobe_n(address_latch_strobe_n),
    .irq_service_in(irq_service_in), .data_oe_n(data_oe_n),
    .transceiver_disable_out(transceiver_disable_out),
    .interrupt_out(interrupt_out), .rx_tick_out(rx_tick_out),
    .terminal_ready_n_out(terminal_ready_n_out),
    .user_output_one_n(user_output_one_n),
    .user_output_two_n(user_output_two_n),
    .modem_control_reg_q(modem_control_reg_q),
    .reg_read_stb(reg_read_stb), .reg_write_stb(reg_write_stb));

//--- tb/usp_modem.sv
// far-side model: modem status pins and the receive clock
// assumes the bench sets levels just after a clock edge
`timescale 1ns/10ps
module usp_modem
    import usp_pkg::*;
(
    input wire logic clock,
    input wire logic [3:0] lvl,
    input wire logic rclk_en,
    output usp_pkg::usp_modem_in_t modem_in,
    output logic rclk_in
);
    logic [1:0] c;
    initial begin
        modem_in = 4'hF;
        rclk_in = 1'h0;
        c = 2'h0;
    end
    // rclk stands still unless enabled; eight clocks a period
    always @(posedge clock) begin
        c <= c + 2'h1;
        modem_in <= #2 lvl;
        if (rclk_en && c == 2'h3) rclk_in <= #2 ~rclk_in;
    end
endmodule

//--- tb/tb.sv
// self-checking bench: host access task plus table-driven checks
// assumes usp_pkg, usp_pins, the checker and the modem model
`timescale 1ns/10ps
module tb;
    import usp_pkg::*;
    logic clock, rst_n, mr, as_n, rd_n, wr_n, svc, fifo, acts, ren;
    logic rclk, dis, intr, tick, wstb, dtr_n, o1_n, o2_n;
    logic rd, hi, rts_n, perm;
    logic [2:0] rs = 3'h0, rsq;
    logic [3:0] ien = 4'h0, lvl = 4'hF, au = 4'h8;
    logic [7:0] din = 8'h00, dout, oe_n, modem_control_reg, d, q;
    usp_sel_t sel = 3'h6;
    usp_irq_src_t src = 4'h0;
    usp_modem_in_t mdm;
    int err_total = 0, n_tests = 0, t, n;
    // control value and expected {rts, dtr, user_output_one, user_output_two} pins
    logic [7:0] mv[4] = '{8'h0D, 8'h1D, 8'h06, 8'h00};
    logic [7:0] mx[4] = '{8'h08, 8'h0F, 8'h05, 8'h0F};
    usp_sel_t bs[3] = '{3'h7, 3'h2, 3'h4};
    // pin bit, change flag bit, level bit
    int pb[4] = '{3, 2, 0, 3}, fb[4] = '{0, 1, 3, 0}, lb[4] = '{4, 5, 7, 4};
    // {source, enable, fifo mode, expected interrupt}
    logic [9:0] iv[6] = '{10'h049, 10'h040, 10'h084, 10'h087, 10'h105,
        10'h211};
    usp_pins i_usp_pins (.clock(clock), .rst_n(rst_n), .master_reset_in(mr),
        .chip_sel_in(sel), .address_latch_strobe_n(as_n), .reg_sel_in(rs),
        .read_n_in(rd_n), .read_in(rd), .write_n_in(wr_n), .data_in(din),
        .data_out(dout), .data_oe_n(oe_n), .transceiver_disable_out(dis),
        .modem_in(mdm), .rclk_in(rclk), .irq_src_in(src), .rx_tick_out(tick),
        .irq_enable_in(ien), .fifo_mode_in(fifo), .auto_cts_in(acts),
        .irq_service_in(svc), .interrupt_out(intr), .reg_write_stb(wstb),
        .terminal_ready_n_out(dtr_n), .request_send_n_out(rts_n),
        .tx_permit_out(perm),
        .user_output_one_n(o1_n), .user_output_two_n(o2_n),
        .modem_control_reg_q(modem_control_reg), .reg_sel_q(rsq), .reg_read_stb());
    usp_modem i_usp_modem (.clock(clock), .lvl(lvl), .rclk_en(ren),
        .modem_in(mdm), .rclk_in(rclk));
    always #25 clock = ~clock;
    task automatic cyc(input int c);
        repeat (c) @(posedge clock);
        #2;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: %h vs %h", $time, g, e);
        end
    endtask
    // one host access; ok low means no answer may come
    task automatic acc(input logic w, input logic [2:0] a,
        input logic [7:0] v, input logic ok);
        rs = a;
        din = v;
        wr_n = !w;
        rd_n = w | hi;
        rd = !w & hi;
        for (t = 0; t < 8 && (w ? wstb : !dis) !== 1'h1; t++) cyc(1);
        if (ok && (w ? wstb : !dis) !== 1'h1) results(1'h1);
        if (!ok) chk({7'h0, dis}, 8'h01);
        q = dout;
        {rd_n, wr_n} = 2'h3;
        rd = 1'h0;
        cyc(3);
    endtask
    task automatic results(input logic hang);
        if (hang) err_total++;
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {clock, rst_n, mr, as_n, svc, fifo, acts, ren} = 8'h00;
        {rd_n, wr_n} = 2'h3;
        {rd, hi} = 2'h0;
        cyc(10);
        rst_n = 1'h1;
        cyc(3);
        chk({3'h0, dtr_n, o1_n, o2_n, dis, intr}, 8'h1E);
        foreach (mv[k]) begin
            acc(1'h1, 3'h4, mv[k], 1'h1);
            acc(1'h0, 3'h4, 8'h00, 1'h1);
            chk(q, mv[k]);
            chk({4'h0, rts_n, dtr_n, o1_n, o2_n}, mx[k]);
            chk({5'h0, rsq}, 8'h04);
        end
        // any single inactive select keeps the device deaf
        foreach (bs[k]) begin
            sel = bs[k];
            acc(1'h1, 3'h4, 8'h01, 1'h0);
            acc(1'h0, 3'h4, 8'h00, 1'h0);
            chk(modem_control_reg, 8'h00);
        end
        // held selects keep the device awake after the pins let go
        sel = 3'h6;
        cyc(3);
        as_n = 1'h1;
        cyc(3);
        sel = 3'h7;
        acc(1'h1, 3'h4, 8'h02, 1'h1);
        chk(modem_control_reg, 8'h02);
        as_n = 1'h0;
        acc(1'h1, 3'h4, 8'h00, 1'h0);
        chk(modem_control_reg, 8'h02);
        // baseline reads, first on the high strobe; no change since reset
        sel = 3'h6;
        ien = 4'h8;
        hi = 1'h1;
        acc(1'h0, 3'h6, 8'h00, 1'h1);
        chk({4'h0, q[3:0]}, 8'h00);
        hi = 1'h0;
        acc(1'h0, 3'h6, 8'h00, 1'h1);
        foreach (pb[k]) begin
            acts = au[k];
            d = q;
            lvl[pb[k]] = ~lvl[pb[k]];
            cyc(8);
            chk({7'h0, intr}, {7'h0, !au[k]});
            chk({7'h0, perm}, {7'h0, !au[k] | !lvl[3]});
            acc(1'h0, 3'h6, 8'h00, 1'h1);
            chk(q ^ d, 8'h01 << fb[k] | 8'h01 << lb[k]);
            svc = 1'h1;
            cyc(1);
            svc = 1'h0;
            acc(1'h0, 3'h6, 8'h00, 1'h1);
            chk({q[3:0], 3'h0, intr}, 8'h00);
        end
        // sources, masking and the fifo-only timeout
        acts = 1'h0;
        foreach (iv[k]) begin
            {src, ien, fifo} = iv[k][9:1];
            cyc(4);
            chk({7'h0, intr}, {7'h0, iv[k][0]});
            svc = 1'h1;
            cyc(1);
            svc = 1'h0;
        end
        // 128 enabled clocks give 16 receive clock rises
        src = 4'h0;
        ren = 1'h1;
        n = 0;
        for (int i = 0; i < 136; i++) begin
            cyc(1);
            n += tick;
            ren = i < 127;
        end
        chk(n[7:0], 8'h10);
        acc(1'h1, 3'h4, 8'h0D, 1'h1);
        {src, ien} = 8'h12;
        mr = 1'h1;
        cyc(6);
        chk({dtr_n, o1_n, o2_n, dis, intr, modem_control_reg[2:0]}, 8'hF0);
        mr = 1'h0;
        cyc(4);
        results(1'h0);
    end
endmodule
